// *** acr_defs.svh ***
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// Register byte addresses
`define ACR_REG_CONFIG 8'h00
`define ACR_REG_STATUS 8'h04
`define ACR_REG_RESULT 8'h08
// Configuration field positions and reset value
`define ACR_CFG_W 4
`define ACR_CFG_STATUS_EN 0
`define ACR_CFG_TURBO 1
`define ACR_CFG_HIZ 2
`define ACR_CFG_SPAN 3
`define ACR_CFG_RESET 4'h0
// Sticky error positions in STATUS[3:0], write 1 to clear
`define ACR_ERR_W 4
`define ACR_ERR_SCK 0
`define ACR_ERR_QUIET1 1
`define ACR_ERR_SELECT 2
`define ACR_ERR_QUIET2 3
// Word layout
`define ACR_RES_W 16
`define ACR_STAT_W 6
`define ACR_WORD_W 22
`define ACR_LEN_PLAIN 5'h10
`define ACR_LEN_STATUS 5'h16
// Timing defaults in clk_i cycles
`define ACR_CONV_MIN_CYC 12
`define ACR_CONV_MAX_CYC 20
`define ACR_QUIET1_CYC 4
`define ACR_QUIET2_CYC 4
`endif

// *** acr_host_model.sv ***
`timescale 1ns/1ns
module acr_host_model (
  input wire logic clk_i, // System clock
  input wire logic data_i, // Serial result from the device
  input wire logic drive_i, // Device output enable
  output logic start_o, // Convert-start pin
  output logic select_o, // Serial input and select pin
  output logic sclk_o // Serial clock, idle low
);
  logic line;

  // Pull-up holds the line high once the device lets go
  assign line = drive_i ? data_i : 1'b1;

  // Select idles high, the clock stands still between frames
  initial begin
    start_o = 1'b0;
    select_o = 1'b1;
    sclk_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Convert edge with select high; pins parked well before the minimum time
  task automatic start(input logic start_lvl, input logic sel_lvl, output logic oe_mid);
    tick(1);
    start_o <= 1'b0;
    select_o <= 1'b1;
    tick(2);
    start_o <= 1'b1;
    tick(3);
    start_o <= start_lvl;
    select_o <= sel_lvl;
    tick(5);
    @(negedge clk_i) oe_mid = drive_i; // No clock activity here
  endtask

  // One 320 ns clock period; sampled on the high half, well after the last fall
  task automatic pulse(inout logic [31:0] w);
    tick(1);
    sclk_o <= 1'b1;
    tick(2);
    @(negedge clk_i) w = {w[30:0], line};
    tick(2);
    sclk_o <= 1'b0;
    tick(3);
  endtask

  // Busy modes take one extra fall to release; non-busy frames open on select
  task automatic read(input logic busy, input int n, output logic [31:0] w,
                      output logic oe_end);
    w = 32'h0000_0000;
    if (!busy) begin
      tick(1);
      select_o <= 1'b0;
      tick(3);
    end
    repeat (busy ? n + 1 : n) pulse(w);
    tick(5);
    @(negedge clk_i) oe_end = drive_i;
    tick(1);
    select_o <= 1'b1;
  endtask
endmodule // acr_host_model

// *** acr_pkg.sv ***
package acr_pkg;
  // Pin levels sampled from the link
  typedef struct packed {
    logic convert_start;
    logic serial_in_select;
    logic sck;
  } acr_pin_s;

  typedef struct packed {
    logic span;
    logic hiz;
    logic turbo;
    logic status_en;
  } acr_cfg_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_ARMED = 2'b01,
    RD_SEND = 2'b10
  } acr_rd_e;

  typedef enum logic [1:0] {
    MD_BUSY3 = 2'b00,
    MD_BUSY4 = 2'b01,
    MD_NBUSY4 = 2'b10,
    MD_TURBO4 = 2'b11
  } acr_mode_e;

  typedef struct packed {
    acr_pin_s s1;
    acr_pin_s s2;
    acr_pin_s s3;
  } acr_sync_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    acr_cfg_s cfg;
    logic [3:0] err;
  } acr_regs_s;
endpackage

// *** acr_readout.sv ***
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "acr_defs.svh"
module acr_readout
  import acr_pkg::*;
#(
  parameter int CONV_MIN_CYC = `ACR_CONV_MIN_CYC,
  parameter int CONV_MAX_CYC = `ACR_CONV_MAX_CYC,
  parameter int QUIET1_CYC = `ACR_QUIET1_CYC,
  parameter int QUIET2_CYC = `ACR_QUIET2_CYC
) (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic convert_start_i, // Convert-start pin
  input wire logic serial_in_select_i, // Serial input / select pin
  input wire logic serial_clock_i, // Host serial clock pin
  input wire logic [15:0] conv_result_i, // Result from the converter core
  input wire logic overvoltage_clamp_flag_i, // Clamp flag from the core
  output logic serial_result_out_o, // Serial data out
  output logic serial_result_out_oe_o // Output enable, high drives
);
  // Whole state of the readout engine
  typedef struct packed {
    acr_rd_e rd;
    acr_mode_e mode;
    logic conv_on;
    logic [15:0] conv_cnt;
    logic [15:0] q2_cnt;
    logic [1:0] sel_min;
    logic [15:0] latest;
    logic [15:0] prev;
    logic [21:0] word;
    logic [4:0] bit_cnt;
    logic [4:0] total;
    logic serial_result_out;
    logic oe;
    logic [3:0] err;
  } acr_main_s;

  acr_main_s q;
  acr_main_s next_q;
  acr_pin_s lv;
  acr_pin_s rise;
  acr_pin_s fall;
  acr_cfg_s cfg;
  logic conv_done;
  logic busy_go;
  logic arm_go;
  logic turbo_go;

  // Result followed by the six status bits
  function automatic logic [21:0] make_word(input logic [15:0] res, input acr_cfg_s c,
                                            input logic ov);
    make_word = {res, ov, c.span, c.hiz, c.turbo, 2'b00};
  endfunction

  // Bit shown at position idx, MSB first
  function automatic logic bit_at(input logic [21:0] w, input logic [4:0] idx);
    bit_at = w[5'd21 - idx];
  endfunction

  function automatic logic [4:0] frame_len(input acr_cfg_s c);
    frame_len = c.status_en ? `ACR_LEN_STATUS : `ACR_LEN_PLAIN;
  endfunction

  acr_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i('{convert_start: convert_start_i, serial_in_select: serial_in_select_i, sck: serial_clock_i}),
    .lvl_o(lv),
    .rise_o(rise),
    .fall_o(fall)
  );

  acr_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .err_set_i(q.err),
    .state_i({q.conv_on, q.mode, q.rd}),
    .result_i(q.latest),
    .cfg_o(cfg)
  );

  // Decisions taken this cycle, shared with the checks below
  assign conv_done = q.conv_on && (q.conv_cnt == 16'(CONV_MAX_CYC - 1));
  assign busy_go = conv_done && !cfg.turbo && (!lv.convert_start || !lv.serial_in_select) && !rise.convert_start;
  assign arm_go = (q.rd == RD_ARMED) && fall.serial_in_select && !rise.convert_start;
  assign turbo_go = (q.rd == RD_IDLE) && cfg.turbo && lv.convert_start && fall.serial_in_select && !rise.convert_start;

  // Conversion timer, readout engine and host timing monitors
  always_comb begin
    next_q = q;
    next_q.err = '0;
    // Time since the last falling clock edge, saturating
    if (fall.sck) begin
      next_q.q2_cnt = '0;
    end else if (q.q2_cnt != 16'hffff) begin
      next_q.q2_cnt = q.q2_cnt + 16'h0001;
    end
    // Conversion runs to its maximum time unless a new convert_start rise restarts it
    if (q.conv_on) begin
      next_q.conv_cnt = q.conv_cnt + 16'h0001;
      if (q.conv_cnt == 16'(CONV_MIN_CYC - 1)) begin
        next_q.sel_min = {lv.convert_start, lv.serial_in_select};
      end
      // A clock during conversion couples into the sample; only logged, and only when turbo is off
      if (fall.sck && !cfg.turbo) begin
        next_q.err[`ACR_ERR_SCK] = 1'b1;
      end
    end
    if (conv_done) begin
      next_q.conv_on = 1'b0;
      next_q.latest = conv_result_i;
      // Fast readout never gives a busy indication
      if (!cfg.turbo) begin
        next_q.word = make_word(conv_result_i, cfg, overvoltage_clamp_flag_i);
        next_q.total = frame_len(cfg);
        next_q.bit_cnt = 5'h00;
        if ({lv.convert_start, lv.serial_in_select} != q.sel_min) begin
          next_q.err[`ACR_ERR_SELECT] = 1'b1;
        end
        if (!lv.convert_start) begin
          next_q.mode = MD_BUSY3;
        end else if (!lv.serial_in_select) begin
          next_q.mode = MD_BUSY4;
        end else begin
          next_q.mode = MD_NBUSY4;
        end
        if (!lv.convert_start || !lv.serial_in_select) begin
          // Falling output acts as the host's interrupt
          next_q.rd = RD_SEND;
          next_q.oe = 1'b1;
          next_q.serial_result_out = 1'b0;
        end else begin
          next_q.rd = RD_ARMED;
        end
      end
    end
    case (q.rd)
      RD_IDLE: begin
        // Previous result is ready at once, so reading overlaps conversion
        if (turbo_go) begin
          next_q.mode = MD_TURBO4;
          next_q.word = make_word(q.prev, cfg, overvoltage_clamp_flag_i);
          next_q.total = frame_len(cfg);
          next_q.bit_cnt = 5'h01;
          next_q.rd = RD_SEND;
          next_q.oe = 1'b1;
          next_q.serial_result_out = bit_at(next_q.word, 5'h00);
          if (q.conv_on && (q.conv_cnt < 16'(QUIET1_CYC))) begin
            next_q.err[`ACR_ERR_QUIET1] = 1'b1;
          end
        end
      end
      RD_ARMED: begin
        // Select falling edge puts the MSB out immediately
        if (arm_go) begin
          next_q.bit_cnt = 5'h01;
          next_q.rd = RD_SEND;
          next_q.oe = 1'b1;
          next_q.serial_result_out = bit_at(q.word, 5'h00);
        end
      end
      RD_SEND: begin
        if ((q.mode == MD_NBUSY4) && rise.serial_in_select) begin
          next_q.rd = RD_IDLE;
          next_q.oe = 1'b0;
        end else if (fall.sck) begin
          // Busy modes start at zero, so the extra edge ends the frame
          if (q.bit_cnt >= q.total) begin
            next_q.rd = RD_IDLE;
            next_q.oe = 1'b0;
          end else begin
            // Bit changes only on falling edges and holds across both
            next_q.serial_result_out = bit_at(q.word, q.bit_cnt);
            next_q.bit_cnt = q.bit_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_q.rd = RD_IDLE;
      end
    endcase
    // Convert start overrides everything: new sample, output released
    if (rise.convert_start) begin
      next_q.conv_on = 1'b1;
      next_q.conv_cnt = 16'h0000;
      next_q.prev = q.latest;
      next_q.rd = RD_IDLE;
      next_q.oe = 1'b0;
      if ((q.mode == MD_TURBO4 || q.mode == MD_NBUSY4) && (q.q2_cnt < 16'(QUIET2_CYC))) begin
        next_q.err[`ACR_ERR_QUIET2] = 1'b1;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.q2_cnt <= 16'hffff;
      q.sel_min <= 2'b11;
    end else begin
      q <= next_q;
    end
  end

  assign serial_result_out_o = q.serial_result_out;
  assign serial_result_out_oe_o = q.oe;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_cnv_hiz: assert property (rise.convert_start |=> !serial_result_out_oe_o)
    else $error("Output still driven after convert start");
  chk_conv_quiet: assert property ((q.conv_on && !cfg.turbo) |-> !q.oe)
    else $error("Output driven during a conversion");
  chk_busy_low: assert property (busy_go |=> (q.oe && !q.serial_result_out && q.bit_cnt == 5'h00))
    else $error("Busy indication missing at conversion end");
  chk_msb_first: assert property ((arm_go || turbo_go) |=> (q.oe && q.serial_result_out == q.word[21]))
    else $error("MSB not shown on select fall");
  chk_frame_len: assert property (($fell(q.oe) && $past(fall.sck))
                                  |-> $past(q.bit_cnt) == $past(q.total))
    else $error("Frame ended at wrong falling edge");
  chk_total_len: assert property ((busy_go || arm_go || turbo_go)
                                  |=> q.total == ($past(cfg.status_en) ? 5'h16 : 5'h10))
    else $error("Frame length does not follow status enable");
  chk_status_order: assert property (busy_go |=> q.word[5:0] == {$past(overvoltage_clamp_flag_i),
                                     $past(cfg.span), $past(cfg.hiz), 3'b000})
    else $error("Status bits out of order");
  chk_bit_hold: assert property ((q.oe && !fall.sck && !rise.convert_start) |=> $stable(q.serial_result_out))
    else $error("Output bit changed between falling edges");
  chk_nb_release: assert property ((q.rd == RD_SEND && q.mode == MD_NBUSY4 && rise.serial_in_select)
                                   |=> !q.oe)
    else $error("Non-busy output not released on select rise");
  chk_turbo_prev: assert property (turbo_go |=> q.word[21:6] == $past(q.prev))
    else $error("Fast readout did not send previous result");
  chk_turbo_nobusy: assert property ((conv_done && cfg.turbo && q.rd == RD_IDLE && !fall.serial_in_select)
                                     |=> !q.oe)
    else $error("Busy indication in fast readout");
  chk_turbo_reset: assert property (disable iff (1'b0) rst_i |=> !cfg.turbo)
    else $error("Fast readout set after reset");
  chk_conv_time: assert property (($fell(q.conv_on) && !$past(rise.convert_start))
                                  |-> $past(q.conv_cnt) == 16'(CONV_MAX_CYC - 1))
    else $error("Conversion ended at wrong time");

  cov_busy3: cover property ((q.mode == MD_BUSY3 && q.rd == RD_SEND && fall.sck) ##1 $fell(q.oe));
  cov_nbusy4: cover property (arm_go ##[1:400] $fell(q.oe));
  cov_turbo: cover property (turbo_go ##[1:400] rise.convert_start);
  cov_status: cover property (q.rd == RD_SEND && q.total == 5'h16 && q.bit_cnt == 5'h16);
endmodule // acr_readout

// *** acr_readout_tb.sv ***
`timescale 1ns/1ns
module acr_readout_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic start_pin;
  logic select_pin;
  logic sclk_pin;
  logic data;
  logic drive;
  logic [15:0] conv_result_i = 16'h0000;
  logic clamp = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [31:0] w;
  logic oe_mid;
  logic oe_end;

  always #20 clk_i = ~clk_i;

  acr_readout acr_readout_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convert_start_i(start_pin),
    .serial_in_select_i(select_pin), .serial_clock_i(sclk_pin),
    .conv_result_i(conv_result_i), .overvoltage_clamp_flag_i(clamp),
    .serial_result_out_o(data), .serial_result_out_oe_o(drive)
  );

  acr_host_model host_i (
    .clk_i(clk_i), .data_i(data), .drive_i(drive), .start_o(start_pin),
    .select_o(select_pin), .sclk_o(sclk_pin)
  );

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled, bounded wait
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd_o);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    // Look between edges so the launching edge is never raced
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd_o = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask

  // Configure, convert, read a whole frame; later result changes must not leak in
  task automatic run_mode(input logic [3:0] cfg, input logic st_lvl, input logic sel_lvl,
                          input logic busy, input logic [15:0] res, input logic cf);
    logic [31:0] exp;
    wb_xfer(1'b1, 8'h00, {28'h000_0000, cfg}, rd);
    wb_xfer(1'b0, 8'h00, 32'h0000_0000, rd);
    check(rd, {28'h000_0000, cfg});
    clamp <= cf;
    conv_result_i <= res;
    host_i.start(st_lvl, sel_lvl, oe_mid);
    check({31'h0000_0000, oe_mid}, 32'h0000_0000);
    repeat (24) @(posedge clk_i);
    conv_result_i <= ~res;
    host_i.read(busy, cfg[0] ? 22 : 16, w, oe_end);
    exp = cfg[0] ? {10'h000, res, cf, cfg[3], cfg[2], cfg[1], 2'b00} : {16'h0000, res};
    check(w, exp);
    check({31'h0000_0000, oe_end}, 32'h0000_0000);
    wb_xfer(1'b0, 8'h08, 32'h0000_0000, rd);
    check(rd, {16'h0000, res});
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b0, 8'h00, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wb_xfer(1'b0, 8'h0C, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    // 3-wire busy, 4-wire busy with status, 4-wire without busy
    run_mode(4'h0, 1'b0, 1'b1, 1'b1, 16'h8001, 1'b0);
    run_mode(4'hD, 1'b1, 1'b0, 1'b1, 16'h6A95, 1'b1);
    run_mode(4'h0, 1'b1, 1'b1, 1'b0, 16'hC37E, 1'b0);
    // Turbo: a frame opened during a conversion carries the word before it
    wb_xfer(1'b1, 8'h00, 32'h0000_0003, rd);
    clamp <= 1'b1;
    conv_result_i <= 16'hA5C3;
    host_i.start(1'b1, 1'b1, oe_mid);
    repeat (24) @(posedge clk_i);
    conv_result_i <= 16'h3C5A;
    host_i.start(1'b1, 1'b1, oe_mid);
    check({31'h0000_0000, oe_mid}, 32'h0000_0000);
    host_i.read(1'b0, 22, w, oe_end);
    check(w, {10'h000, 16'hA5C3, 6'h24});
    check({31'h0000_0000, oe_end}, 32'h0000_0000);
    repeat (8) @(posedge clk_i);
    // Short frame left open, then cut by the next convert edge
    host_i.start(1'b1, 1'b1, oe_mid);
    host_i.read(1'b0, 4, w, oe_end);
    check(w, 32'h0000_0003);
    check({31'h0000_0000, oe_end}, 32'h0000_0001);
    host_i.start(1'b1, 1'b1, oe_mid);
    check({31'h0000_0000, oe_mid}, 32'h0000_0000);
    // A well-behaved host leaves no sticky error behind
    wb_xfer(1'b0, 8'h04, 32'h0000_0000, rd);
    check({28'h000_0000, rd[3:0]}, 32'h0000_0000);
    conclude();
  end
endmodule // acr_readout_tb

// *** acr_sync.sv ***
`timescale 1ns/1ns
module acr_sync
  import acr_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input acr_pin_s pins_i, // Raw link pins
  output acr_pin_s lvl_o, // Synchronised levels
  output acr_pin_s rise_o, // One-cycle rise pulses
  output acr_pin_s fall_o // One-cycle fall pulses
);
  acr_sync_s q;
  acr_sync_s next_q;

  // Two stages against metastability, the third only for edge detection
  always_comb begin
    next_q = q;
    next_q.s1 = pins_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      // Select idles high; resetting it low would fake a rise after reset
      q.s1.serial_in_select <= 1'b1;
      q.s2.serial_in_select <= 1'b1;
      q.s3.serial_in_select <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Only the second and third stages feed logic
  assign lvl_o = q.s2;
  assign rise_o = acr_pin_s'(q.s2 & ~q.s3);
  assign fall_o = acr_pin_s'(~q.s2 & q.s3);
endmodule // acr_sync

// *** acr_wb_regs.sv ***
`timescale 1ns/1ns
`include "acr_defs.svh"
module acr_wb_regs
  import acr_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [3:0] err_set_i, // Error set pulses
  input wire logic [4:0] state_i, // Conversion and readout state
  input wire logic [15:0] result_i, // Latest result
  output acr_cfg_s cfg_o // Configuration
);
  acr_regs_s q;
  acr_regs_s next_q;
  logic req;

  // One wait state: answer on the edge after the request is seen
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;

  always_comb begin
    next_q = q;
    next_q.ack = req;
    next_q.err = q.err | err_set_i;
    next_q.dat = 32'h0000_0000;
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `ACR_REG_CONFIG) begin
        next_q.cfg = acr_cfg_s'(wb_dat_i[`ACR_CFG_W-1:0]);
      end
      // Set wins over clear so no event is lost
      if (wb_adr_i == `ACR_REG_STATUS) begin
        next_q.err = (q.err & ~wb_dat_i[`ACR_ERR_W-1:0]) | err_set_i;
      end
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `ACR_REG_CONFIG: next_q.dat = {28'h000_0000, q.cfg};
        `ACR_REG_STATUS: next_q.dat = {23'h00_0000, state_i, q.err};
        `ACR_REG_RESULT: next_q.dat = {16'h0000, result_i};
        default: next_q.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cfg <= acr_cfg_s'(`ACR_CFG_RESET);
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign cfg_o = q.cfg;
endmodule // acr_wb_regs
